//--- pfm_ctrl.sv
// Memory controller end of the processor fast memory port, with its own word array.
// Assumes the processor end shares CLK_SYS_I and keeps its side of the handshake.
//
// What this block does
// - Four access types: read, read-hold, write, byte
// - Read loads output latch, no restore phase
// - Read-hold pauses, reserved until following write or word read
// - Processor writes after read-hold unless parity error
// - Word write stores 16 bits, no clearing
// - Byte write stores one byte, address picks
// - Processor places byte on selected lane
// - 18-bit address from six and twelve lines
// - Separate one-way 16-bit read and write paths
// - Active-low start begins the access cycle
// - Selected only when address in range
// - Complete only after control-ok from processor
// - Active-low sync marks cycle being completed
// - Two active-low lines give access type
// - Abort signal cancels acknowledged access cycle
// - Active-low parity error flag on error
// - Processor acknowledges parity error indication
// - Up to four matrices, one technology
// - Codes 00 read,01 hold,10 write,11 byte
// - Sync with high bit strobes write data
// - Processor samples flag when dropping control-ok
`timescale 1ns/100ps
`default_nettype none
module pfm_ctrl #(
  parameter int unsigned     MATRIX_COUNT = 4,
  parameter int unsigned     WORDS_PER_MATRIX = 256,
  parameter logic [17:0]     RANGE_BASE   = pfm_pkg::RANGE_BASE_RST,
  parameter logic [17:0]     RANGE_LIMIT  = pfm_pkg::RANGE_LIMIT_RST,
  parameter int unsigned     ACCESS_CYC   = pfm_pkg::ACCESS_CYC
) (
  input  wire logic CLK_SYS_I,
  input  wire logic RSTN_I,
  pfm_if.ctrl       BUS,
  input  wire logic PARITY_INJECT_I,
  output logic      BUSY_O,
  output logic      HOLD_RESERVED_O
);

  localparam int unsigned DEPTH = MATRIX_COUNT * WORDS_PER_MATRIX;
  localparam int unsigned IDX_W = $clog2(DEPTH);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACCESS, ST_WAIT_OK, ST_SYNC, ST_HOLD
  } pfm_ctrl_st_t;

  logic [15:0]        mem_q [DEPTH];
  logic [1:0]         parity_q [DEPTH];
  pfm_ctrl_st_t       st_q, st_d;
  pfm_pkg::pfm_acc_t  acc_q, acc_d;
  logic [17:0]        addr_q, addr_d;
  logic [3:0]         cnt_q, cnt_d;
  logic [15:0]        rdata_q, rdata_d;
  logic               perr_q, perr_d;
  logic               hold_q, hold_d;
  logic               sel_q, sel_d;
  logic [17:0]        addr_in;
  pfm_pkg::pfm_acc_t  acc_in;
  logic               in_range;
  logic               data_latch;
  logic [IDX_W-1:0]   idx;
  logic               par_bad;

  function automatic logic [1:0] byte_par(input logic [15:0] w);
    byte_par = {^w[15:8], ^w[7:0]};
  endfunction : byte_par

  assign addr_in  = {BUS.addr_high_lines, BUS.addr_low_lines};
  assign acc_in   = pfm_pkg::pfm_acc_t'({~BUS.access_type_bit1_n, ~BUS.access_type_bit0_n});
  assign in_range = (addr_in >= RANGE_BASE) && (addr_in <= RANGE_LIMIT)
                    && ((addr_in - RANGE_BASE) >> 1) < 18'(DEPTH);
  assign idx      = IDX_W'((addr_q - RANGE_BASE) >> 1);
  assign par_bad  = (byte_par(mem_q[idx]) != parity_q[idx]) || PARITY_INJECT_I;
  // Write strobe only while sync is out on a write type
  assign data_latch = (st_q == ST_SYNC) && acc_q[1];

  always_comb begin
    st_d    = st_q;
    acc_d   = acc_q;
    addr_d  = addr_q;
    cnt_d   = cnt_q;
    rdata_d = rdata_q;
    perr_d  = perr_q;
    hold_d  = hold_q;
    sel_d   = sel_q;
    // Flag released on acknowledge; a new error in the same cycle wins
    if (BUS.parity_err_ack) begin
      perr_d = 1'b0;
    end
    case (st_q)
      ST_IDLE, ST_HOLD: begin
        sel_d = 1'b0;
        if (!BUS.bus_start_n && in_range && (st_q == ST_IDLE || addr_in == addr_q)) begin
          sel_d  = 1'b1;
          acc_d  = acc_in;
          addr_d = addr_in;
          cnt_d  = 4'(ACCESS_CYC);
          st_d   = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (cnt_q > 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          st_d = ST_WAIT_OK;
        end
      end
      ST_WAIT_OK: begin
        if (BUS.control_ok) begin
          st_d = ST_SYNC;
        end
      end
      ST_SYNC: begin
        sel_d = 1'b0;
        if (!acc_q[1]) begin
          rdata_d = mem_q[idx];
          if (par_bad) begin
            perr_d = 1'b1;
          end
        end
        // Hold reserved after read-hold unless a parity error was seen
        hold_d = (acc_q == pfm_pkg::ACC_READ_HOLD) && !par_bad;
        st_d   = ((acc_q == pfm_pkg::ACC_READ_HOLD) && !par_bad) ? ST_HOLD : ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (!BUS.cycle_abort_n && sel_q && (st_q == ST_ACCESS || st_q == ST_WAIT_OK)) begin
      st_d   = hold_q ? ST_HOLD : ST_IDLE;
      sel_d  = 1'b0;
    end
    if (st_q == ST_SYNC && acc_q[1]) begin
      hold_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_q    <= ST_IDLE;
      acc_q   <= pfm_pkg::ACC_WORD_READ;
      addr_q  <= '0;
      cnt_q   <= '0;
      rdata_q <= pfm_pkg::RDATA_RST;
      perr_q  <= 1'b0;
      hold_q  <= 1'b0;
      sel_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      acc_q   <= acc_d;
      addr_q  <= addr_d;
      cnt_q   <= cnt_d;
      rdata_q <= rdata_d;
      perr_q  <= perr_d;
      hold_q  <= hold_d;
      sel_q   <= sel_d;
    end
  end

  // Array write, no clearing pass needed
  always_ff @(posedge CLK_SYS_I) begin
    if (data_latch) begin
      if (acc_q == pfm_pkg::ACC_WORD_WRITE) begin
        mem_q[idx]    <= BUS.write_data_lines;
        parity_q[idx] <= byte_par(BUS.write_data_lines);
      end else if (addr_q[pfm_pkg::BYTE_SEL_POS]) begin
        mem_q[idx][15:8]  <= BUS.write_data_lines[15:8];
        parity_q[idx][1]  <= ^BUS.write_data_lines[15:8];
      end else begin
        mem_q[idx][7:0]   <= BUS.write_data_lines[7:0];
        parity_q[idx][0]  <= ^BUS.write_data_lines[7:0];
      end
    end
  end

  assign BUS.read_data_lines   = rdata_q;
  assign BUS.mem_selected_n    = ~sel_q;
  assign BUS.mem_sync_n        = ~(st_q == ST_SYNC);
  assign BUS.parity_err_flag_n = ~perr_q;
  assign BUSY_O                = (st_q != ST_IDLE) && (st_q != ST_HOLD);
  assign HOLD_RESERVED_O       = hold_q;

endmodule : pfm_ctrl
`default_nettype wire

//--- pfm_if.sv
// Interface joining the processor end and the memory controller end.
// Assumes both ends share CLK_SYS_I; all signals are one-way.
`timescale 1ns/100ps
`default_nettype none
interface pfm_if;
  logic [5:0]  addr_low_lines;
  logic [11:0] addr_high_lines;
  logic [15:0] read_data_lines;
  logic [15:0] write_data_lines;
  logic        bus_start_n;
  logic        mem_selected_n;
  logic        control_ok;
  logic        mem_sync_n;
  logic        access_type_bit0_n;
  logic        access_type_bit1_n;
  logic        cycle_abort_n;
  logic        parity_err_flag_n;
  logic        parity_err_ack;

  modport ctrl (
    input  addr_low_lines, addr_high_lines, write_data_lines, bus_start_n, control_ok,
           access_type_bit0_n, access_type_bit1_n, cycle_abort_n, parity_err_ack,
    output read_data_lines, mem_selected_n, mem_sync_n, parity_err_flag_n
  );

  modport proc (
    output addr_low_lines, addr_high_lines, write_data_lines, bus_start_n, control_ok,
           access_type_bit0_n, access_type_bit1_n, cycle_abort_n, parity_err_ack,
    input  read_data_lines, mem_selected_n, mem_sync_n, parity_err_flag_n
  );
endinterface : pfm_if
`default_nettype wire

//--- pfm_pkg.sv
// Constants and types shared by both ends of the processor fast memory port.
// Assumes a single 25 MHz system clock on both ends.
package pfm_pkg;

  localparam int unsigned ADDR_W      = 18;
  localparam int unsigned ADDR_LO_W   = 6;
  localparam int unsigned ADDR_HI_W   = 12;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned BYTE_SEL_POS = 0;

  // Access type, high bit first, as seen after inverting the active-low lines
  typedef enum logic [1:0] {
    ACC_WORD_READ  = 2'b00,
    ACC_READ_HOLD  = 2'b01,
    ACC_WORD_WRITE = 2'b10,
    ACC_BYTE_WRITE = 2'b11
  } pfm_acc_t;

  localparam logic [17:0] RANGE_BASE_RST  = 18'h0_0000;
  localparam logic [17:0] RANGE_LIMIT_RST = 18'h0_FFFF;
  localparam logic [15:0] RDATA_RST       = 16'h0000;

  // Array access time in ns and its cycle count at 25 MHz, rounded up
  localparam int unsigned ACCESS_NS       = 200;
  localparam int unsigned CLK_NS          = 40;
  localparam int unsigned ACCESS_CYC      = (ACCESS_NS + CLK_NS - 1) / CLK_NS;

endpackage : pfm_pkg

//--- pfm_proc.sv
// Processor end of the processor fast memory port: turns a user request into one access.
// Assumes the controller end shares CLK_SYS_I.
`timescale 1ns/100ps
`default_nettype none
module pfm_proc (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RSTN_I,
  pfm_if.proc              BUS,
  input  wire logic        REQ_I,
  input  wire logic [1:0]  ACC_I,
  input  wire logic [17:0] ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        ABORT_I,
  output logic             READY_O,
  output logic             DONE_O,
  output logic [15:0]      RDATA_O,
  output logic             PERR_O,
  output logic             NOSEL_O
);

  typedef enum logic [2:0] {
    PS_IDLE, PS_START, PS_SEL, PS_OK, PS_DROP, PS_ACK
  } pfm_proc_st_t;

  pfm_proc_st_t       st_q, st_d;
  pfm_pkg::pfm_acc_t  acc_q, acc_d;
  logic [17:0]        addr_q, addr_d;
  logic [15:0]        wdata_q, wdata_d;
  logic [15:0]        rdata_q, rdata_d;
  logic               done_q, done_d;
  logic               perr_q, perr_d;
  logic               nosel_q, nosel_d;
  logic               abort_q, abort_d;

  always_comb begin
    st_d    = st_q;
    acc_d   = acc_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d  = 1'b0;
    perr_d  = perr_q;
    nosel_d = 1'b0;
    abort_d = 1'b0;
    case (st_q)
      PS_IDLE: begin
        if (REQ_I) begin
          acc_d   = pfm_pkg::pfm_acc_t'(ACC_I);
          addr_d  = ADDR_I;
          // Byte goes on the lane that the address selects
          wdata_d = (ACC_I == pfm_pkg::ACC_BYTE_WRITE)
                    ? (ADDR_I[pfm_pkg::BYTE_SEL_POS] ? {WDATA_I[7:0], WDATA_I[7:0]} : WDATA_I)
                    : WDATA_I;
          perr_d  = 1'b0;
          st_d    = PS_START;
        end
      end
      PS_START: begin
        // Select answers one cycle after start
        st_d = PS_SEL;
      end
      PS_SEL: begin
        if (!BUS.mem_selected_n) begin
          st_d = PS_OK;
        end else begin
          nosel_d = 1'b1;
          done_d  = 1'b1;
          st_d    = PS_IDLE;
        end
      end
      PS_OK: begin
        if (ABORT_I) begin
          abort_d = 1'b1;
          done_d  = 1'b1;
          st_d    = PS_IDLE;
        end else if (!BUS.mem_sync_n) begin
          st_d = PS_DROP;
        end
      end
      PS_DROP: begin
        rdata_d = BUS.read_data_lines;
        // Flag sampled as control-ok falls
        if (!BUS.parity_err_flag_n) begin
          perr_d = 1'b1;
          st_d   = PS_ACK;
        end else begin
          done_d = 1'b1;
          st_d   = PS_IDLE;
        end
      end
      PS_ACK: begin
        if (BUS.parity_err_flag_n) begin
          done_d = 1'b1;
          st_d   = PS_IDLE;
        end
      end
      default: begin
        st_d = PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_q    <= PS_IDLE;
      acc_q   <= pfm_pkg::ACC_WORD_READ;
      addr_q  <= '0;
      wdata_q <= '0;
      rdata_q <= pfm_pkg::RDATA_RST;
      done_q  <= 1'b0;
      perr_q  <= 1'b0;
      nosel_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      acc_q   <= acc_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q  <= done_d;
      perr_q  <= perr_d;
      nosel_q <= nosel_d;
      abort_q <= abort_d;
    end
  end

  assign BUS.addr_low_lines     = addr_q[5:0];
  assign BUS.addr_high_lines    = addr_q[17:6];
  assign BUS.write_data_lines   = wdata_q;
  assign BUS.bus_start_n        = ~(st_q == PS_START);
  assign BUS.control_ok         = (st_q == PS_OK);
  assign BUS.access_type_bit1_n = ~acc_q[1];
  assign BUS.access_type_bit0_n = ~acc_q[0];
  assign BUS.cycle_abort_n      = ~abort_q;
  assign BUS.parity_err_ack     = (st_q == PS_ACK);
  assign READY_O                = (st_q == PS_IDLE);
  assign DONE_O                 = done_q;
  assign RDATA_O                = rdata_q;
  assign PERR_O                 = perr_q;
  assign NOSEL_O                = nosel_q;

endmodule : pfm_proc
`default_nettype wire

//--- pfm_props.sv
// Concurrent checks on the handshake between the two port ends.
// Assumes instantiation beside the pfm_if that joins both ends.
`timescale 1ns/100ps
`default_nettype none
module pfm_props #(
  parameter logic [17:0] LIMIT = pfm_pkg::RANGE_LIMIT_RST
) (
  input wire logic        CLK_SYS_I,
  input wire logic        RSTN_I,
  input wire logic [5:0]  addr_low_lines,
  input wire logic [11:0] addr_high_lines,
  input wire logic [15:0] read_data_lines,
  input wire logic        bus_start_n,
  input wire logic        mem_selected_n,
  input wire logic        control_ok,
  input wire logic        mem_sync_n,
  input wire logic        cycle_abort_n,
  input wire logic        parity_err_flag_n,
  input wire logic        parity_err_ack
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  wire logic in_range = ({addr_high_lines, addr_low_lines} <= LIMIT);

  // Selected, then access count runs without abort
  sequence access_s;
    ($fell(mem_selected_n) && cycle_abort_n) ##1 cycle_abort_n [*5];
  endsequence

  sel_in_range_a: assert property (!bus_start_n && in_range |=> !mem_selected_n)
    else $error("select missing after start");
  sel_out_range_a: assert property (!bus_start_n && !in_range && mem_selected_n |=> mem_selected_n)
    else $error("select for foreign address");
  sel_after_start_a: assert property ($fell(mem_selected_n) |-> !$past(bus_start_n))
    else $error("select without start");
  sync_after_ok_a: assert property ($fell(mem_sync_n) |-> $past(control_ok))
    else $error("sync without control ok");
  sync_single_a: assert property (!mem_sync_n |=> mem_sync_n)
    else $error("sync longer than one cycle");
  sync_timing_a: assert property (access_s |=> !mem_sync_n)
    else $error("sync not at end of access");
  abort_stops_a: assert property (!cycle_abort_n && !mem_selected_n |=> mem_sync_n [*6])
    else $error("sync after abort");
  flag_held_a: assert property (!parity_err_flag_n && !parity_err_ack |=> !parity_err_flag_n)
    else $error("parity flag dropped early");
  flag_release_a: assert property ($rose(parity_err_ack) |-> ##[1:4] parity_err_flag_n)
    else $error("parity flag not released");
  rdata_stable_a: assert property ($changed(read_data_lines) |-> !mem_sync_n || !$past(mem_sync_n))
    else $error("read latch changed outside sync");
endmodule : pfm_props
`default_nettype wire

//--- tb.sv
// Self-checking bench: processor end and controller end joined by pfm_if.
// Assumes the default range 0..0xFFFF and the default access count.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_sys  = 1'b0;
  logic        rstn     = 1'b0;
  logic        req      = 1'b0;
  logic [1:0]  acc_type = 2'b00;
  logic [17:0] addr     = 18'h0_0000;
  logic [15:0] wdata    = 16'h0000;
  logic        abort    = 1'b0;
  logic        inject   = 1'b0;
  logic        ready;
  logic        done;
  logic        perr;
  logic        nosel;
  logic        busy;
  logic        hold_res;
  logic [15:0] rdata;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #20 clk_sys = ~clk_sys;

  pfm_if pfm_if_i ();
  pfm_ctrl pfm_ctrl_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn), .BUS(pfm_if_i.ctrl), .PARITY_INJECT_I(inject),
    .BUSY_O(busy), .HOLD_RESERVED_O(hold_res));
  pfm_proc pfm_proc_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn), .BUS(pfm_if_i.proc), .REQ_I(req), .ACC_I(acc_type),
    .ADDR_I(addr), .WDATA_I(wdata), .ABORT_I(abort), .READY_O(ready), .DONE_O(done), .RDATA_O(rdata),
    .PERR_O(perr), .NOSEL_O(nosel));
  pfm_props pfm_props_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn), .addr_low_lines(pfm_if_i.addr_low_lines),
    .addr_high_lines(pfm_if_i.addr_high_lines), .read_data_lines(pfm_if_i.read_data_lines),
    .bus_start_n(pfm_if_i.bus_start_n), .mem_selected_n(pfm_if_i.mem_selected_n),
    .control_ok(pfm_if_i.control_ok), .mem_sync_n(pfm_if_i.mem_sync_n), .cycle_abort_n(pfm_if_i.cycle_abort_n),
    .parity_err_flag_n(pfm_if_i.parity_err_flag_n), .parity_err_ack(pfm_if_i.parity_err_ack));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic start(input logic [1:0] t, input logic [17:0] a, input logic [15:0] d);
    for (int i = 0; i < 40 && ready !== 1'b1; i++) @(negedge clk_sys);
    acc_type = t;
    addr = a;
    wdata = d;
    req = 1'b1;
    @(negedge clk_sys);
    req = 1'b0;
  endtask : start

  task automatic access(input logic [1:0] t, input logic [17:0] a, input logic [15:0] d);
    start(t, a, d);
    for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge clk_sys);
    check("done", 16'h0001, {15'h0000, done});
  endtask : access

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (3000) @(posedge clk_sys);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    check("reset rdata", 16'h0000, rdata);
    access(2'b10, 18'h0_0010, 16'h1234);
    access(2'b00, 18'h0_0010, 16'h0000);
    check("word read", 16'h1234, rdata);
    access(2'b11, 18'h0_0011, 16'h00ab);
    access(2'b11, 18'h0_0010, 16'h00cd);
    access(2'b00, 18'h0_0010, 16'h0000);
    check("byte lanes", 16'habcd, rdata);
    access(2'b01, 18'h0_0010, 16'h0000);
    check("hold data", 16'habcd, rdata);
    check("hold flag", 16'h0001, {15'h0000, hold_res});
    access(2'b10, 18'h0_0010, 16'h5a5a);
    check("hold end", 16'h0000, {15'h0000, hold_res});
    access(2'b01, 18'h1_0000, 16'h0000);
    check("not selected", 16'h0001, {15'h0000, nosel});
    inject = 1'b1;
    access(2'b00, 18'h0_0010, 16'h0000);
    check("parity error", 16'h0001, {15'h0000, perr});
    access(2'b01, 18'h0_0010, 16'h0000);
    check("hold skipped", 16'h0000, {15'h0000, hold_res});
    inject = 1'b0;
    access(2'b00, 18'h0_0010, 16'h0000);
    check("parity clear", 16'h0000, {15'h0000, perr});
    check("read after hold", 16'h5a5a, rdata);
    start(2'b10, 18'h0_0010, 16'hffff);
    @(negedge clk_sys);
    abort = 1'b1;
    repeat (2) @(negedge clk_sys);
    abort = 1'b0;
    for (int i = 0; i < 40 && (ready !== 1'b1 || busy !== 1'b0); i++) @(negedge clk_sys);
    check("abort idle", 16'h0000, {15'h0000, busy});
    access(2'b00, 18'h0_0010, 16'h0000);
    check("aborted write", 16'h5a5a, rdata);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
